// File: copper_link_status_register.sv
// Copper link status register with control, interrupt and Wishbone slave.
`timescale 1ns/1ps

// Notes on behaviour
// - Speed at bits 15:14: 00 10M, 01 100M, 10 1000M; reset 10.
// - Speed, duplex, pause, crossover fields valid only while bit 11 is 1.
// - Bit 11 is 1 when negotiation is done or off; resets clear it.
// - Bit 13 shows duplex: 1 full, 0 half.
// - Bit 12 latches high when a page arrives; both resets clear it.
// - Bit 10 follows the live copper link state without latching.
// - Bits 9 and 8 show transmit and receive pause; they steer nothing.
// - Bit 6 shows MDIX 1 or MDI 0, reset 1; mirrors manual setting.
// - A written crossover mode takes effect only at the next software reset.
// - Bit 4 is 1 while the port sleeps, 0 while active.
// - Bit 3 shows global link status, 1 when the copper link is up.
// - Bit 1 is live receive polarity, 1 reversed; reversal can be disabled.
// - Bit 0 is 1 while jabber is detected.
// - With reversal disabled, 10 Mbps operation reports normal polarity.
// - Crossover 00 manual MDI, 01 manual MDIX, 11 automatic, 10 reserved.
module copper_link_status_register
  import copper_status_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [SEL_W-1:0]  wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  // Results from the negotiation, link and crossover engines
  input  wire logic              an_done_i,
  input  wire logic [1:0]        speed_i,
  input  wire logic              full_duplex_i,
  input  wire logic              tx_pause_i,
  input  wire logic              rx_pause_i,
  input  wire logic              page_rx_i,
  input  wire logic              link_up_i,
  input  wire logic              mdix_det_i,
  input  wire logic              sleep_i,
  input  wire logic              pol_reversed_i,
  input  wire logic              jabber_i,
  // Settings in effect and interrupt
  output logic      [1:0]        xover_mode_o,
  output logic                   pol_rev_dis_o,
  output logic                   an_enable_o,
  output logic                   soft_rst_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic             [REG_W-1:0] ctrl;
  logic             [REG_W-1:0] irq_mask;
  logic             [REG_W-1:0] irq_stat;
  logic             [REG_W-1:0] stat;
  logic             [REG_W-1:0] next_stat;
  logic             [REG_W-1:0] next_ev;
  logic             [REG_W-1:0] irq_rd_clr;
  logic             [REG_W-1:0] wr_val;
  logic             [REG_W-1:0] rd_val;
  logic             [IDX_W-1:0] idx;
  speed_t                       speed;
  xover_t                       next_xover;
  logic                         duplex;
  logic                         tx_pause;
  logic                         rx_pause;
  logic                         mdix;
  logic                         next_mdix;
  logic                         resolved;
  logic                         capture;
  logic                         page_flag;
  logic                         page_rd_clr;
  logic                         pol_shown;
  logic                         req;
  logic                         take;
  logic                         wr;
  logic                         rd;

  // ---------------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------------
  assign req  = wb_cyc_i & wb_stb_i;
  assign take = req & wb_ack_o;
  assign wr   = take & wb_we_i;
  assign rd   = take & ~wb_we_i;
  assign idx  = wb_adr_i[IDX_LO +: IDX_W];

  // Every access is answered one cycle after it is presented.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // Read data is captured with the answer; unmapped indices read zero.
  always_comb begin
    rd_val = REG_ZERO;
    if (idx == IDX_CTRL) begin
      rd_val = ctrl;
    end else if (idx == IDX_STATUS) begin
      rd_val = stat;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_val = irq_mask;
    end else if (idx == IDX_IRQ_STAT) begin
      rd_val = irq_stat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (req && !wb_ack_o) begin
      wb_dat_o <= {{(DATA_W-REG_W){1'b0}}, rd_val};
    end
  end

  // ---------------------------------------------------------------------
  // Byte lane merge for writes
  // ---------------------------------------------------------------------
  function automatic logic [REG_W-1:0] merge(
    input logic [REG_W-1:0]  old_v,
    input logic [DATA_W-1:0] dat,
    input logic [SEL_W-1:0]  sel
  );
    logic [REG_W-1:0] v;
    v = old_v;
    if (sel[0]) begin
      v[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      v[15:8] = dat[15:8];
    end
    return v;
  endfunction

  assign wr_val = merge(ctrl, wb_dat_i, wb_sel_i);

  // ---------------------------------------------------------------------
  // Control register and software reset
  // ---------------------------------------------------------------------
  // The reset request bit is self clearing and always reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= CTRL_RST;
    end else if (wr && idx == IDX_CTRL) begin
      ctrl <= wr_val & CTRL_WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_o <= 1'b0;
    end else begin
      soft_rst_o <= wr && idx == IDX_CTRL && wr_val[SOFT_RST];
    end
  end

  // The stored mode is applied only by a software reset, because a
  // crossover change mid-link would disrupt traffic.
  always_comb begin
    next_xover = xover_mode_o;
    if (ctrl[XOVER_HI:XOVER_LO] != XOVER_RSVD) begin
      next_xover = ctrl[XOVER_HI:XOVER_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xover_mode_o <= XOVER_RST;
    end else if (soft_rst_o) begin
      xover_mode_o <= next_xover;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pol_rev_dis_o <= 1'b0;
    end else begin
      pol_rev_dis_o <= ctrl[POL_DIS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      an_enable_o <= 1'b1;
    end else begin
      an_enable_o <= ctrl[AN_EN];
    end
  end

  // ---------------------------------------------------------------------
  // Resolution results
  // ---------------------------------------------------------------------
  // Results track the engine only while they are valid, and keep their
  // last value through a software reset.
  assign capture = ~ctrl[AN_EN] | an_done_i;

  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst_o) begin
      resolved <= 1'b0;
    end else begin
      resolved <= capture;
    end
  end

  // Manual modes mirror the selected setting; auto reports the engine.
  assign next_mdix = (xover_mode_o == XOVER_AUTO) ? mdix_det_i
                                                  : xover_mode_o[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed <= SPEED_RST;
    end else if (capture) begin
      speed <= speed_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duplex <= 1'b0;
    end else if (capture) begin
      duplex <= full_duplex_i;
    end
  end

  // Pause results are only reported; nothing in the block acts on them.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_pause <= 1'b0;
      rx_pause <= 1'b0;
    end else if (capture) begin
      tx_pause <= tx_pause_i;
      rx_pause <= rx_pause_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mdix <= MDIX_RST;
    end else if (capture) begin
      mdix <= next_mdix;
    end
  end

  // ---------------------------------------------------------------------
  // Page received flag
  // ---------------------------------------------------------------------
  // Only a flag that was seen as set by the read is cleared.
  assign page_rd_clr = rd && idx == IDX_STATUS && wb_dat_o[PAGE];

  sticky_bits #(
    .W (1)
  ) u_page (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (soft_rst_o),
    .set_i    (page_rx_i),
    .rd_clr_i (page_rd_clr),
    .q_o      (page_flag)
  );

  // ---------------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------------
  // With reversal disabled the 10 Mbps receiver is forced to normal.
  assign pol_shown = pol_reversed_i &
                     ~(ctrl[POL_DIS] && speed == SPEED_10);

  always_comb begin
    next_stat              = REG_ZERO;
    next_stat[SPD_HI:SPD_LO] = speed;
    next_stat[DUPLEX]      = duplex;
    next_stat[PAGE]        = page_flag;
    next_stat[RESOLVED]    = resolved;
    next_stat[LINK_RT]     = link_up_i;
    next_stat[TX_PAUSE]    = tx_pause;
    next_stat[RX_PAUSE]    = rx_pause;
    next_stat[MDIX]        = mdix;
    next_stat[SLEEP]       = sleep_i;
    next_stat[GLOBAL_LINK] = link_up_i;
    next_stat[POLARITY]    = pol_shown;
    next_stat[JABBER]      = jabber_i;
  end

  // Live fields lag their inputs by one cycle through this register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat <= STATUS_RST;
    end else begin
      stat <= next_stat;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------------
  // Events sit at the position of the status field they watch.
  always_comb begin
    next_ev         = (next_stat ^ stat) & IRQ_EVENT_MASK;
    next_ev[SPD_HI] = next_stat[SPD_HI] != stat[SPD_HI] ||
                      next_stat[SPD_LO] != stat[SPD_LO];
    next_ev[PAGE]   = page_rx_i;
    next_ev[RESOLVED] = next_stat[RESOLVED] & ~stat[RESOLVED];
  end

  assign irq_rd_clr = (rd && idx == IDX_IRQ_STAT) ? wb_dat_o[REG_W-1:0]
                                                   : REG_ZERO;

  sticky_bits #(
    .W (REG_W)
  ) u_irq (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .clear_i  (1'b0),
    .set_i    (next_ev),
    .rd_clr_i (irq_rd_clr),
    .q_o      (irq_stat)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= REG_ZERO;
    end else if (wr && idx == IDX_IRQ_MASK) begin
      irq_mask <= merge(irq_mask, wb_dat_i, wb_sel_i) & IRQ_EVENT_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

endmodule

// File: copper_link_status_register_sva.sv
// Port-level checks of the copper link status register block.
`timescale 1ns/1ps
module copper_link_status_register_sva
  import copper_status_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADR_W-1:0]  wb_adr_i,
  input wire logic [SEL_W-1:0]  wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  input wire logic [DATA_W-1:0] wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              an_done_i,
  input wire logic [1:0]        speed_i,
  input wire logic              full_duplex_i,
  input wire logic              tx_pause_i,
  input wire logic              rx_pause_i,
  input wire logic              page_rx_i,
  input wire logic              link_up_i,
  input wire logic              mdix_det_i,
  input wire logic              sleep_i,
  input wire logic              pol_reversed_i,
  input wire logic              jabber_i,
  input wire logic [1:0]        xover_mode_o,
  input wire logic              pol_rev_dis_o,
  input wire logic              an_enable_o,
  input wire logic              soft_rst_o,
  input wire logic              irq_o
);
  // -------------------------------------------------------------------
  // Helper logic
  // -------------------------------------------------------------------
  // Field checks wait until inputs and settings have been still, since
  // latched fields need two cycles and a read returns an older word.
  logic [15:0] ins;
  logic [15:0] last;
  logic [2:0]  calm;
  logic        st_rd;
  assign ins = {an_done_i, speed_i, full_duplex_i, tx_pause_i, rx_pause_i,
                link_up_i, mdix_det_i, sleep_i, pol_reversed_i, jabber_i,
                xover_mode_o, pol_rev_dis_o, an_enable_o};
  assign st_rd = wb_ack_o && !wb_we_i && wb_adr_i[7:2] == IDX_STATUS;
  always_ff @(posedge clk_i) begin
    last <= ins;
    if (rst_i || soft_rst_o || ins != last) begin
      calm <= 3'h0;
    end else if (calm != 3'h7) begin
      calm <= calm + 3'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // -------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack late");
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_hi_zero;
    wb_ack_o |-> wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper data set");
  property p_live;
    st_rd && calm >= 3'h5 |-> wb_dat_o[LINK_RT] == link_up_i &&
      wb_dat_o[GLOBAL_LINK] == link_up_i && wb_dat_o[SLEEP] == sleep_i &&
      wb_dat_o[JABBER] == jabber_i;
  endproperty
  a_live: assert property (p_live)
    else $error("live field");
  property p_resolved;
    st_rd && calm >= 3'h5 |->
      wb_dat_o[RESOLVED] == (an_done_i || !an_enable_o);
  endproperty
  a_resolved: assert property (p_resolved) else $error("resolved");
  property p_fields;
    st_rd && calm >= 3'h5 && wb_dat_o[RESOLVED] |->
      wb_dat_o[SPD_HI:SPD_LO] == speed_i && wb_dat_o[DUPLEX] == full_duplex_i
      && wb_dat_o[TX_PAUSE] == tx_pause_i && wb_dat_o[RX_PAUSE] == rx_pause_i;
  endproperty
  a_fields: assert property (p_fields)
    else $error("fields");
  property p_mdix;
    st_rd && calm >= 3'h5 && wb_dat_o[RESOLVED] |-> wb_dat_o[MDIX] ==
      ((xover_mode_o == XOVER_AUTO) ? mdix_det_i : xover_mode_o[0]);
  endproperty
  a_mdix: assert property (p_mdix) else $error("crossover bit");
  property p_pol;
    st_rd && calm >= 3'h5 && wb_dat_o[RESOLVED] |-> wb_dat_o[POLARITY] ==
      (pol_reversed_i && !(pol_rev_dis_o && speed_i == SPEED_10));
  endproperty
  a_pol: assert property (p_pol) else $error("polarity");
  property p_xover;
    xover_mode_o != XOVER_RSVD && ($stable(xover_mode_o) || soft_rst_o ||
      $past(soft_rst_o) || $past(rst_i));
  endproperty
  a_xover: assert property (p_xover)
    else $error("crossover mode");
  c_status_rd: cover property (st_rd && wb_dat_o[RESOLVED]);
  c_soft_rst: cover property (soft_rst_o);
  c_irq: cover property ($rose(irq_o));
endmodule

bind copper_link_status_register copper_link_status_register_sva chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .an_done_i(an_done_i), .speed_i(speed_i), .full_duplex_i(full_duplex_i),
  .tx_pause_i(tx_pause_i), .rx_pause_i(rx_pause_i), .page_rx_i(page_rx_i),
  .link_up_i(link_up_i), .mdix_det_i(mdix_det_i), .sleep_i(sleep_i),
  .pol_reversed_i(pol_reversed_i), .jabber_i(jabber_i),
  .xover_mode_o(xover_mode_o), .pol_rev_dis_o(pol_rev_dis_o),
  .an_enable_o(an_enable_o), .soft_rst_o(soft_rst_o), .irq_o(irq_o));

// File: copper_status_pkg.sv
// Constants, field positions and reset values of the copper link status block.
package copper_status_pkg;

  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADR_W  = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;
  localparam int REG_W  = 16;
  localparam int IDX_W  = 6;
  localparam int IDX_LO = 2;

  // ---------------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ---------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_CTRL     = 6'h10;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 6'h11;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h12;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 6'h13;

  // ---------------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------------
  localparam int SPD_HI      = 15;
  localparam int SPD_LO      = 14;
  localparam int DUPLEX      = 13;
  localparam int PAGE        = 12;
  localparam int RESOLVED    = 11;
  localparam int LINK_RT     = 10;
  localparam int TX_PAUSE    = 9;
  localparam int RX_PAUSE    = 8;
  localparam int MDIX        = 6;
  localparam int SLEEP       = 4;
  localparam int GLOBAL_LINK = 3;
  localparam int POLARITY    = 1;
  localparam int JABBER      = 0;

  // ---------------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------------
  localparam int SOFT_RST = 15;
  localparam int AN_EN    = 12;
  localparam int XOVER_HI = 6;
  localparam int XOVER_LO = 5;
  localparam int POL_DIS  = 1;

  // ---------------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------------
  typedef logic [1:0] speed_t;
  localparam speed_t SPEED_10   = 2'h0;
  localparam speed_t SPEED_100  = 2'h1;
  localparam speed_t SPEED_1000 = 2'h2;
  localparam speed_t SPEED_RST  = SPEED_1000;

  typedef logic [1:0] xover_t;
  localparam xover_t XOVER_MDI  = 2'h0;
  localparam xover_t XOVER_MDIX = 2'h1;
  localparam xover_t XOVER_RSVD = 2'h2;
  localparam xover_t XOVER_AUTO = 2'h3;
  localparam xover_t XOVER_RST  = XOVER_AUTO;

  localparam logic             MDIX_RST       = 1'b1;
  localparam logic [REG_W-1:0] STATUS_RST     = 16'h8040;
  localparam logic [REG_W-1:0] CTRL_RST       = 16'h1060;
  localparam logic [REG_W-1:0] CTRL_WR_MASK   = 16'h1062;
  localparam logic [REG_W-1:0] IRQ_EVENT_MASK = 16'hbc53;
  localparam logic [REG_W-1:0] REG_ZERO       = 16'h0000;

endpackage

// File: sticky_bits.sv
// Sticky flags set by hardware events and cleared by a read or a reset.
`timescale 1ns/1ps
module sticky_bits #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         clear_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] rd_clr_i,
  output logic      [W-1:0] q_o
);

  // A set in the cycle of a read clear wins, so no event is lost.
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      q_o <= '0;
    end else begin
      q_o <= set_i | (q_o & ~rd_clr_i);
    end
  end

endmodule

// File: tb_copper_link_status_register.sv
// Self-checking bench for the copper link status register block.
`timescale 1ns/1ps
module tb_copper_link_status_register;
  import copper_status_pkg::*;
  localparam logic [ADR_W-1:0] A_CT = {IDX_CTRL, 2'h0};
  localparam logic [ADR_W-1:0] A_ST = {IDX_STATUS, 2'h0};
  localparam logic [ADR_W-1:0] A_MK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [ADR_W-1:0] A_IS = {IDX_IRQ_STAT, 2'h0};
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADR_W-1:0]  wb_adr_i = 8'h00;
  logic [SEL_W-1:0]  wb_sel_i = 4'hf;
  logic [DATA_W-1:0] wb_dat_i = 32'h0, wb_dat_o;
  logic              wb_ack_o, soft_rst_o, irq_o, pol_rev_dis_o, an_enable_o;
  logic [1:0]        speed_i = 2'h0, xover_mode_o;
  logic              an_done_i = 1'b0, full_duplex_i = 1'b0, tx_pause_i = 1'b0;
  logic              rx_pause_i = 1'b0, page_rx_i = 1'b0, link_up_i = 1'b0;
  logic              mdix_det_i = 1'b0, sleep_i = 1'b0, jabber_i = 1'b0;
  logic              pol_reversed_i = 1'b0;
  int                fails = 0, tests_run = 0, cycles = 0, srst = 0;
  copper_link_status_register dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .an_done_i(an_done_i), .speed_i(speed_i), .full_duplex_i(full_duplex_i),
    .tx_pause_i(tx_pause_i), .rx_pause_i(rx_pause_i), .page_rx_i(page_rx_i),
    .link_up_i(link_up_i), .mdix_det_i(mdix_det_i), .sleep_i(sleep_i),
    .pol_reversed_i(pol_reversed_i), .jabber_i(jabber_i),
    .xover_mode_o(xover_mode_o), .pol_rev_dis_o(pol_rev_dis_o),
    .an_enable_o(an_enable_o), .soft_rst_o(soft_rst_o), .irq_o(irq_o));
  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  always begin
    #5 clk_i = ~clk_i;
  end
  task automatic print_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // The ceiling is far above the few hundred cycles the run needs.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      fails++;
      print_verdict();
    end
  end
  // Software reset pulses are counted so scenarios can check each one.
  always @(posedge clk_i) begin
    if (soft_rst_o === 1'b1) begin
      srst++;
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic [ADR_W-1:0] adr, input logic we,
                      input logic [15:0] dat, output logic [15:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {16'h0000, dat};
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [15:0] exp,
                        input string nm);
    logic [15:0] d;
    xfer(adr, 1'b0, 16'h0000, d);
    chk(nm, exp, d);
  endtask
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask
  task automatic pulse_page();
    @(posedge clk_i);
    page_rx_i <= 1'b1;
    @(posedge clk_i);
    page_rx_i <= 1'b0;
    settle();
  endtask
  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    rd_chk(A_ST, STATUS_RST, "status");
    rd_chk(A_CT, CTRL_RST, "ctrl");
    rd_chk(A_MK, REG_ZERO, "mask");
    rd_chk(A_IS, REG_ZERO, "irq_stat");
    rd_chk(8'h3c, REG_ZERO, "unmapped");
    xfer(A_ST, 1'b1, 16'hffff, d);
    rd_chk(A_ST, STATUS_RST, "status write");
  endtask
  task automatic t_live();
    logic [3:0] p;
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? 4'ha : ((i == 1) ? 4'h5 : 4'h0);
      @(posedge clk_i);
      {link_up_i, sleep_i, pol_reversed_i, jabber_i} <= p;
      settle();
      rd_chk(A_ST, STATUS_RST | {5'h0, p[3], 5'h0, p[2], p[3], 1'b0, p[1],
             p[0]}, "live");
    end
  endtask
  task automatic t_resolve();
    logic [15:0] d;
    logic [1:0]  v;
    for (int s = 0; s < 3; s++) begin
      v = 2'(s);
      @(posedge clk_i);
      speed_i       <= v;
      full_duplex_i <= v[0];
      tx_pause_i    <= v[0];
      rx_pause_i    <= ~v[0];
      an_done_i     <= 1'b1;
      settle();
      rd_chk(A_ST, {v, v[0], 3'h2, v[0], ~v[0], 8'h00},
             "resolved");
    end
    @(posedge clk_i);
    an_done_i <= 1'b0;
    xfer(A_CT, 1'b1, 16'h0060, d);
    settle();
    rd_chk(A_CT, 16'h0060, "ctrl");
    chk("an_enable", 16'h0000, 16'(an_enable_o));
    rd_chk(A_ST, 16'h8900, "neg off");
    xfer(A_CT, 1'b1, CTRL_RST, d);
    settle();
    xfer(A_ST, 1'b0, 16'h0000, d);
    chk("unresolved", 16'h0000, d & 16'h0800);
  endtask
  task automatic t_page_irq();
    logic [15:0] d;
    xfer(A_IS, 1'b0, 16'h0000, d);
    xfer(A_MK, 1'b1, 16'hffff, d);
    rd_chk(A_MK, IRQ_EVENT_MASK, "mask");
    xfer(A_MK, 1'b1, 16'h1000, d);
    pulse_page();
    chk("irq", 16'h0001, 16'(irq_o));
    rd_chk(A_ST, 16'h9100, "page set");
    rd_chk(A_ST, 16'h8100, "page clear");
    rd_chk(A_IS, 16'h1000, "irq_stat");
    settle();
    chk("irq clear", 16'h0000, 16'(irq_o));
    xfer(A_MK, 1'b1, 16'h0000, d);
    pulse_page();
    chk("irq masked", 16'h0000, 16'(irq_o));
    xfer(A_CT, 1'b1, 16'h9060, d);
    settle();
    rd_chk(A_ST, 16'h8100, "page soft reset");
  endtask
  task automatic t_xover();
    logic [15:0] d;
    logic [1:0]  ex[4];
    logic [1:0]  pr;
    int          b;
    ex = '{2'h0, 2'h1, 2'h1, 2'h3};
    pr = XOVER_RST;
    b  = srst;
    @(posedge clk_i);
    an_done_i  <= 1'b1;
    mdix_det_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      xfer(A_CT, 1'b1, 16'h1000 | (16'(i) << 5), d);
      settle();
      chk("xover pending", 16'(pr), 16'(xover_mode_o));
      chk("soft_rst held", 16'(b + i), 16'(srst));
      xfer(A_CT, 1'b1, 16'h9000 | (16'(i) << 5), d);
      settle();
      chk("xover applied", 16'(ex[i]), 16'(xover_mode_o));
      chk("soft_rst pulse", 16'(b + i + 1), 16'(srst));
      xfer(A_ST, 1'b0, 16'h0000, d);
      chk("mdix", 16'((ex[i] == XOVER_AUTO) | ex[i][0]),
          16'(d[MDIX]));
      pr = ex[i];
    end
  endtask
  task automatic t_polarity();
    logic [15:0] d;
    xfer(A_CT, 1'b1, 16'h1062, d);
    @(posedge clk_i);
    pol_reversed_i <= 1'b1;
    for (int s = 0; s < 3; s += 2) begin
      @(posedge clk_i);
      speed_i <= 2'(s);
      settle();
      xfer(A_ST, 1'b0, 16'h0000, d);
      chk("polarity", 16'(s != 0), 16'(d[POLARITY]));
    end
    chk("pol_dis", 16'h0001, 16'(pol_rev_dis_o));
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_live();
    t_resolve();
    t_page_irq();
    t_xover();
    t_polarity();
    print_verdict();
  end
endmodule
